// ### msu_pkg.sv
package msu_pkg;

    // microinstruction fields
    localparam int unsigned MSU_MI_W = 16;
    localparam int unsigned MSU_OPC_HI = 15;
    localparam int unsigned MSU_OPC_LO = 9;
    localparam int unsigned MSU_FLAG_BIT = 8;
    localparam int unsigned MSU_SRC_HI = 7;
    localparam int unsigned MSU_SRC_LO = 4;
    localparam int unsigned MSU_DST_HI = 3;
    localparam int unsigned MSU_DST_LO = 0;

    // opcode bits 15:9 of each shift family
    localparam logic [6:0] MSU_OPC_RLBC = 7'h44;
    localparam logic [6:0] MSU_OPC_SLW = 7'h47;
    localparam logic [6:0] MSU_OPC_RLWC = 7'h45;
    localparam logic [6:0] MSU_OPC_SRB = 7'h6e;
    localparam logic [6:0] MSU_OPC_RRBC = 7'h6c;

    // status register bit positions
    localparam int unsigned MSU_B_NB = 7;
    localparam int unsigned MSU_B_ZB = 6;
    localparam int unsigned MSU_B_HC = 5;
    localparam int unsigned MSU_B_CO = 4;
    localparam int unsigned MSU_B_N = 3;
    localparam int unsigned MSU_B_Z = 2;
    localparam int unsigned MSU_B_V = 1;
    localparam int unsigned MSU_B_C = 0;

    // apb map, byte addresses
    localparam logic [11:0] MSU_A_STATUS = 12'h000;
    localparam logic [11:0] MSU_A_ISSUE = 12'h004;
    localparam logic [11:0] MSU_A_COUNT = 12'h008;
    localparam logic [5:0] MSU_A_REGS_PAGE = 6'h01;

    // reset values
    localparam logic [7:0] MSU_STATUS_RST = 8'h00;
    localparam logic [15:0] MSU_OP_RST = 16'h0000;
    localparam logic [15:0] MSU_COUNT_RST = 16'h0000;
    localparam logic [7:0] MSU_BYTE_RST = 8'h00;

    typedef enum logic [2:0] {
        MSU_FAM_NONE,
        MSU_FAM_ROTATE_LEFT_BYTE_CARRY,
        MSU_FAM_SHIFT_LEFT_WORD,
        MSU_FAM_ROTATE_LEFT_WORD_CARRY,
        MSU_FAM_SHIFT_RIGHT_BYTE,
        MSU_FAM_ROTATE_RIGHT_BYTE_CARRY
    } msu_fam_t;

    typedef enum logic [1:0] {
        MSU_S_IDLE,
        MSU_S_EXEC,
        MSU_S_APB
    } msu_state_t;

    function automatic msu_fam_t msu_decode(input logic [15:0] w);
        msu_fam_t f;
        f = MSU_FAM_NONE;
        case (w[MSU_OPC_HI:MSU_OPC_LO])
            MSU_OPC_RLBC: f = MSU_FAM_ROTATE_LEFT_BYTE_CARRY;
            MSU_OPC_SLW: f = MSU_FAM_SHIFT_LEFT_WORD;
            MSU_OPC_RLWC: f = MSU_FAM_ROTATE_LEFT_WORD_CARRY;
            MSU_OPC_SRB: f = MSU_FAM_SHIFT_RIGHT_BYTE;
            MSU_OPC_RRBC: f = MSU_FAM_ROTATE_RIGHT_BYTE_CARRY;
            default: f = MSU_FAM_NONE;
        endcase
        return f;
    endfunction

endpackage

// ### msu_regfile.sv
`timescale 1ns/100ps
module msu_regfile #(
    parameter int unsigned AW = 4,
    parameter int unsigned DW = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [AW-1:0] rd_addr0,
    input wire logic [AW-1:0] rd_addr1,
    output logic [DW-1:0] rd_data0,
    output logic [DW-1:0] rd_data1,
    input wire logic wr_en0,
    input wire logic [AW-1:0] wr_addr0,
    input wire logic [DW-1:0] wr_data0,
    input wire logic wr_en1,
    input wire logic [AW-1:0] wr_addr1,
    input wire logic [DW-1:0] wr_data1
);
    localparam int unsigned DEPTH = 1 << AW;
    logic [DW-1:0] mem_r [DEPTH];

    // port 1 wins a same-address collision; reads see old data
    for (genvar i = 0; i < DEPTH; i++) begin : g_word
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                mem_r[i] <= msu_pkg::MSU_BYTE_RST;
            end else if (wr_en1 && wr_addr1 == AW'(i)) begin
                mem_r[i] <= wr_data1;
            end else if (wr_en0 && wr_addr0 == AW'(i)) begin
                mem_r[i] <= wr_data0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_data0 <= msu_pkg::MSU_BYTE_RST;
            rd_data1 <= msu_pkg::MSU_BYTE_RST;
        end else begin
            rd_data0 <= mem_r[rd_addr0];
            rd_data1 <= mem_r[rd_addr1];
        end
    end
endmodule

// ### msu_seq_model.sv
`timescale 1ns/100ps
module msu_seq_model (
    input wire logic pclk,
    input wire logic mi_ready,
    output logic mi_valid,
    output logic [15:0] mi_word
);
    initial begin
        mi_valid = 1'b0;
        mi_word = 16'h0000;
    end
    // gap > 0 models a slow sequencer; the word is held until taken, for at most 20 cycles
    task automatic send(input logic [15:0] w, input int unsigned gap, output bit ok);
        int n;
        repeat (gap) @(posedge pclk);
        mi_valid <= 1'b1;
        mi_word <= w;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (mi_ready !== 1'b1 && n < 20);
        ok = (mi_ready === 1'b1);
        mi_valid <= 1'b0;
        // idle word flips so nothing can lean on a stale value
        mi_word <= ~w;
    endtask
endmodule

// ### msu_top.sv
`timescale 1ns/100ps
// How it works
// - left byte shift, carry into bit zero
// - even source: pair shifted left into pair
// - odd source: byte sign-extended, then shifted
// - left word shift with carry in
// - right byte shift, zero into bit seven
// - right byte shift, carry into bit seven
// - byte status negative and zero from byte
// - word status negative and zero from word
// - half carry from bit three, left only
// - carry-out status is the shifted-off bit
// - left word flags: carry gets top bit
// - right byte flags: carry gets low bit
// - byte flags: negative and zero from byte
// - word flags: zero over all sixteen bits
// - left flags: overflow set, right keeps it
// - source untouched unless also destination
// - destination from low four field bits
module msu_top #(
    parameter int unsigned NREG_AW = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic mi_valid,
    input wire logic [15:0] mi_word,
    output logic mi_ready,
    output logic op_done,
    output logic byte_negative_status,
    output logic byte_zero_status,
    output logic half_carry_status,
    output logic carry_out_status,
    output logic cc_n,
    output logic cc_z,
    output logic cc_v,
    output logic cc_c
);
    typedef struct packed {
        msu_pkg::msu_state_t state;
        logic [15:0] op;
        logic [7:0] stat;
        logic [15:0] cnt;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic mi_ready;
        logic done;
    } msu_st_t;

    msu_st_t s_r;
    msu_st_t s_nxt;
    msu_pkg::msu_fam_t fam_w;
    logic [7:0] rd0;
    logic [7:0] rd1;
    logic [NREG_AW-1:0] ra0;
    logic [NREG_AW-1:0] ra1;
    logic we0;
    logic we1;
    logic [NREG_AW-1:0] wa0;
    logic [NREG_AW-1:0] wa1;
    logic [7:0] wd0;
    logic [7:0] wd1;
    logic start;
    logic exec;
    logic [15:0] src16;
    logic [15:0] res16;
    logic sh_out;
    logic hc;
    logic ovf;
    logic is_word;
    logic is_left;
    logic upd;
    logic c_in;

    assign fam_w = msu_pkg::msu_decode(s_r.op);
    assign exec = s_r.state == msu_pkg::MSU_S_EXEC;
    assign upd = s_r.op[msu_pkg::MSU_FLAG_BIT];
    assign c_in = s_r.stat[msu_pkg::MSU_B_C];
    // odd source field: sign-extend the single byte
    assign src16 = s_r.op[msu_pkg::MSU_SRC_LO] ? {{8{rd0[7]}}, rd0} : {rd1, rd0};

    msu_regfile #(
        .AW(NREG_AW),
        .DW(8)
    ) u_regs (
        .pclk(pclk),
        .presetn(presetn),
        .rd_addr0(ra0),
        .rd_addr1(ra1),
        .rd_data0(rd0),
        .rd_data1(rd1),
        .wr_en0(we0),
        .wr_addr0(wa0),
        .wr_data0(wd0),
        .wr_en1(we1),
        .wr_addr1(wa1),
        .wr_data1(wd1)
    );

    // shift datapath
    always_comb begin
        res16 = 16'h0000;
        sh_out = 1'b0;
        hc = 1'b0;
        ovf = 1'b0;
        is_word = 1'b0;
        is_left = 1'b0;
        unique case (fam_w)
            msu_pkg::MSU_FAM_ROTATE_LEFT_BYTE_CARRY: begin
                res16 = {8'h00, rd0[6:0], c_in};
                sh_out = rd0[7];
                hc = rd0[3];
                ovf = rd0[7] ^ rd0[6];
                is_left = 1'b1;
            end
            msu_pkg::MSU_FAM_SHIFT_LEFT_WORD: begin
                res16 = {src16[14:0], 1'b0};
                sh_out = src16[15];
                hc = src16[3];
                ovf = src16[15] ^ src16[14];
                is_word = 1'b1;
                is_left = 1'b1;
            end
            msu_pkg::MSU_FAM_ROTATE_LEFT_WORD_CARRY: begin
                res16 = {src16[14:0], c_in};
                sh_out = src16[15];
                hc = src16[3];
                ovf = src16[15] ^ src16[14];
                is_word = 1'b1;
                is_left = 1'b1;
            end
            msu_pkg::MSU_FAM_SHIFT_RIGHT_BYTE: begin
                res16 = {8'h00, 1'b0, rd0[7:1]};
                sh_out = rd0[0];
            end
            msu_pkg::MSU_FAM_ROTATE_RIGHT_BYTE_CARRY: begin
                res16 = {8'h00, c_in, rd0[7:1]};
                sh_out = rd0[0];
            end
            msu_pkg::MSU_FAM_NONE: begin
                res16 = 16'h0000;
            end
        endcase
    end

    always_comb begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        s_nxt.pready = 1'b0;
        s_nxt.pslverr = 1'b0;
        start = 1'b0;
        ra0 = s_r.op[msu_pkg::MSU_SRC_HI:msu_pkg::MSU_SRC_LO];
        ra1 = NREG_AW'(ra0 + 1'b1);
        we0 = 1'b0;
        we1 = 1'b0;
        wa0 = s_r.op[msu_pkg::MSU_DST_HI:msu_pkg::MSU_DST_LO];
        wa1 = NREG_AW'(wa0 + 1'b1);
        wd0 = res16[7:0];
        wd1 = res16[15:8];
        unique case (s_r.state)
            msu_pkg::MSU_S_IDLE: begin
                if (mi_valid && s_r.mi_ready) begin
                    start = 1'b1;
                    s_nxt.op = mi_word;
                end else if (psel && penable && !s_r.pready) begin
                    // apb is served only while no shift is in flight
                    s_nxt.pready = 1'b1;
                    s_nxt.prdata = 32'h0000_0000;
                    if (paddr[11:6] == msu_pkg::MSU_A_REGS_PAGE && paddr[1:0] == 2'b00) begin
                        if (pwrite) begin
                            we0 = 1'b1;
                            wa0 = paddr[NREG_AW+1:2];
                            wd0 = pwdata[7:0];
                        end else begin
                            ra0 = paddr[NREG_AW+1:2];
                            s_nxt.pready = 1'b0;
                            s_nxt.state = msu_pkg::MSU_S_APB;
                        end
                    end else if (paddr == msu_pkg::MSU_A_STATUS) begin
                        if (pwrite) begin
                            s_nxt.stat = pwdata[7:0];
                        end
                        s_nxt.prdata = {24'h000000, s_r.stat};
                    end else if (paddr == msu_pkg::MSU_A_ISSUE) begin
                        if (pwrite) begin
                            start = 1'b1;
                            s_nxt.op = pwdata[15:0];
                        end
                        s_nxt.prdata = {16'h0000, s_r.op};
                    end else if (paddr == msu_pkg::MSU_A_COUNT) begin
                        s_nxt.prdata = {16'h0000, s_r.cnt};
                    end else begin
                        s_nxt.pslverr = 1'b1;
                    end
                end
                if (start) begin
                    ra0 = s_nxt.op[msu_pkg::MSU_SRC_HI:msu_pkg::MSU_SRC_LO];
                    ra1 = NREG_AW'(ra0 + 1'b1);
                    s_nxt.state = msu_pkg::MSU_S_EXEC;
                end
            end
            msu_pkg::MSU_S_EXEC: begin
                s_nxt.state = msu_pkg::MSU_S_IDLE;
                s_nxt.done = 1'b1;
                s_nxt.cnt = 16'(s_r.cnt + 1'b1);
                // only the destination is written
                if (fam_w != msu_pkg::MSU_FAM_NONE) begin
                    we0 = 1'b1;
                    we1 = is_word;
                    if (is_word) begin
                        s_nxt.stat[msu_pkg::MSU_B_NB] = res16[15];
                        s_nxt.stat[msu_pkg::MSU_B_ZB] = res16 == 16'h0000;
                    end else begin
                        s_nxt.stat[msu_pkg::MSU_B_NB] = res16[7];
                        s_nxt.stat[msu_pkg::MSU_B_ZB] = res16[7:0] == 8'h00;
                    end
                    if (is_left) begin
                        s_nxt.stat[msu_pkg::MSU_B_HC] = hc;
                    end
                    s_nxt.stat[msu_pkg::MSU_B_CO] = sh_out;
                    if (upd) begin
                        // condition codes move only for the flag variant
                        s_nxt.stat[msu_pkg::MSU_B_N] = is_word ? res16[15] : res16[7];
                        s_nxt.stat[msu_pkg::MSU_B_Z] = is_word ? res16 == 16'h0000 : res16[7:0] == 8'h00;
                        s_nxt.stat[msu_pkg::MSU_B_C] = sh_out;
                        if (is_left) begin
                            s_nxt.stat[msu_pkg::MSU_B_V] = ovf;
                        end
                    end
                end
            end
            msu_pkg::MSU_S_APB: begin
                s_nxt.state = msu_pkg::MSU_S_IDLE;
                s_nxt.prdata = {24'h000000, rd0};
                s_nxt.pready = 1'b1;
            end
            default: begin
                s_nxt.state = msu_pkg::MSU_S_IDLE;
            end
        endcase
        // ready only for a cycle that will sit in idle
        s_nxt.mi_ready = s_nxt.state == msu_pkg::MSU_S_IDLE;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r.state <= msu_pkg::MSU_S_IDLE;
            s_r.op <= msu_pkg::MSU_OP_RST;
            s_r.stat <= msu_pkg::MSU_STATUS_RST;
            s_r.cnt <= msu_pkg::MSU_COUNT_RST;
            s_r.prdata <= 32'h0000_0000;
            s_r.pready <= 1'b0;
            s_r.pslverr <= 1'b0;
            s_r.mi_ready <= 1'b0;
            s_r.done <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign mi_ready = s_r.mi_ready;
    assign op_done = s_r.done;
    assign byte_negative_status = s_r.stat[msu_pkg::MSU_B_NB];
    assign byte_zero_status = s_r.stat[msu_pkg::MSU_B_ZB];
    assign half_carry_status = s_r.stat[msu_pkg::MSU_B_HC];
    assign carry_out_status = s_r.stat[msu_pkg::MSU_B_CO];
    assign cc_n = s_r.stat[msu_pkg::MSU_B_N];
    assign cc_z = s_r.stat[msu_pkg::MSU_B_Z];
    assign cc_v = s_r.stat[msu_pkg::MSU_B_V];
    assign cc_c = s_r.stat[msu_pkg::MSU_B_C];

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic acc_mi;
    assign acc_mi = mi_valid && mi_ready && s_r.state == msu_pkg::MSU_S_IDLE;

    op_latency_a: assert property (acc_mi |=> exec ##1 op_done)
        else $error("shift did not finish two cycles after issue");
    rlbc_value_a: assert property (exec && fam_w == msu_pkg::MSU_FAM_ROTATE_LEFT_BYTE_CARRY
        |-> we0 && !we1 && wd0 == {rd0[6:0], cc_c})
        else $error("left byte carry shift wrote a wrong byte");
    slw_pair_a: assert property (exec && fam_w == msu_pkg::MSU_FAM_SHIFT_LEFT_WORD && !s_r.op[4]
        |-> {wd1, wd0} == {rd1[6:0], rd0, 1'b0})
        else $error("even word shift wrote a wrong pair");
    sext_odd_a: assert property (exec && is_word && s_r.op[4] |-> wd1 == {{7{rd0[7]}}, rd0[7]})
        else $error("odd source byte was not sign-extended");
    rlwc_low_a: assert property (exec && fam_w == msu_pkg::MSU_FAM_ROTATE_LEFT_WORD_CARRY
        |-> wd0[0] == cc_c && we1)
        else $error("left word carry shift lost the carry in");
    rrbc_top_a: assert property (exec && fam_w == msu_pkg::MSU_FAM_ROTATE_RIGHT_BYTE_CARRY
        |-> wd0 == {cc_c, rd0[7:1]})
        else $error("right byte carry shift wrote a wrong byte");
    srb_top_a: assert property (exec && fam_w == msu_pkg::MSU_FAM_SHIFT_RIGHT_BYTE |-> wd0[7] == 1'b0)
        else $error("right byte shift did not clear the top bit");
    hc_right_a: assert property (exec && fam_w != msu_pkg::MSU_FAM_NONE && !is_left
        |=> $stable(half_carry_status) && $stable(cc_v))
        else $error("right shift touched half carry or overflow");
    co_bit_a: assert property (exec && fam_w != msu_pkg::MSU_FAM_NONE
        |=> carry_out_status == $past(sh_out) && byte_zero_status == $past(is_word ? res16 == 16'h0000
            : res16[7:0] == 8'h00))
        else $error("carry-out or zero status wrong after shift");
    cc_hold_a: assert property (exec && !upd
        |=> $stable(cc_n) && $stable(cc_z) && $stable(cc_v) && $stable(cc_c))
        else $error("condition codes moved without the flag bit");
    cc_copy_a: assert property (exec && upd && fam_w != msu_pkg::MSU_FAM_NONE
        |=> cc_n == byte_negative_status && cc_z == byte_zero_status
            && cc_c == carry_out_status)
        else $error("condition codes disagree with status bits");
    dst_only_a: assert property (exec && we0 |-> wa0 == s_r.op[3:0])
        else $error("write went elsewhere than the destination");
    apb_ready_a: assert property (psel && penable && !pready && s_r.state == msu_pkg::MSU_S_IDLE
        && !acc_mi |-> ##[1:2] pready)
        else $error("apb access not answered in time");
    hc_left_a: assert property (exec && is_left |=> half_carry_status == $past(is_word ? src16[3] : rd0[3]))
        else $error("left shift half carry status wrong");
    nb_word_a: assert property (exec && is_word |=> byte_negative_status == $past(wd1[7]))
        else $error("word shift negative status wrong");
    v_left_a: assert property (exec && upd && is_left
        |=> cc_v == $past(is_word ? src16[15] ^ src16[14] : rd0[7] ^ rd0[6]))
        else $error("left shift overflow code wrong");
    c_word_a: assert property (exec && upd && is_word |=> cc_c == $past(src16[15]))
        else $error("word shift carry code is not the top bit");

    left_word_c: cover property (exec && upd && fam_w == msu_pkg::MSU_FAM_ROTATE_LEFT_WORD_CARRY);
    right_byte_c: cover property (exec && upd && fam_w == msu_pkg::MSU_FAM_ROTATE_RIGHT_BYTE_CARRY);
    odd_src_c: cover property (exec && fam_w == msu_pkg::MSU_FAM_SHIFT_LEFT_WORD && s_r.op[4]);
    back_back_c: cover property (acc_mi ##2 acc_mi);
    left_byte_c: cover property (exec && upd && fam_w == msu_pkg::MSU_FAM_ROTATE_LEFT_BYTE_CARRY);
endmodule

// ### msu_top_test.sv
`timescale 1ns/100ps
module msu_top_test;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready, pslverr, mi_valid, mi_ready, op_done;
    logic [15:0] mi_word;
    wire [7:0] sts;
    int n_errors = 0;
    int checks = 0;
    int done_cnt = 0;
    int n_ops = 0;
    logic [31:0] lf = 32'h187d976d;
    logic [7:0] rf [16];
    logic [7:0] st;
    logic [15:0] last_w = 16'h0000;

    always #4 pclk = ~pclk;
    always @(posedge pclk) if (op_done === 1'b1) done_cnt <= done_cnt + 1;

    msu_top #(.NREG_AW(4)) i_msu_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mi_valid(mi_valid), .mi_word(mi_word), .mi_ready(mi_ready),
        .op_done(op_done), .byte_negative_status(sts[7]), .byte_zero_status(sts[6]),
        .half_carry_status(sts[5]), .carry_out_status(sts[4]), .cc_n(sts[3]), .cc_z(sts[2]),
        .cc_v(sts[1]), .cc_c(sts[0]));
    msu_seq_model i_msu_seq_model (.pclk(pclk), .mi_ready(mi_ready), .mi_valid(mi_valid), .mi_word(mi_word));

    function automatic logic [31:0] rnd();
        lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
        return lf;
    endfunction

    task automatic summarize;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        // register-file reads take one extra wait cycle
        chk(32'(n), (!wr && a[11:6] == msu_pkg::MSU_A_REGS_PAGE && a[1:0] == 2'b00) ? 32'd3 : 32'd2);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk(q, exp);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
        chk({31'h0, e}, 32'h0);
    endtask

    function automatic logic [11:0] ra(input logic [3:0] i);
        return {msu_pkg::MSU_A_REGS_PAGE, i, 2'b00};
    endfunction

    function automatic void predict(input logic [15:0] w);
        logic [7:0] b;
        logic [15:0] x, r;
        logic c, co, neg, zero, wd, left;
        b = rf[w[7:4]];
        x = w[4] ? {{8{b[7]}}, b} : {rf[w[7:4] + 4'h1], b};
        c = st[msu_pkg::MSU_B_C];
        wd = 1'b0;
        left = 1'b1;
        case (w[15:9])
            msu_pkg::MSU_OPC_RLBC: begin r = {8'h00, b[6:0], c}; co = b[7]; end
            msu_pkg::MSU_OPC_SLW: begin r = {x[14:0], 1'b0}; co = x[15]; wd = 1'b1; end
            msu_pkg::MSU_OPC_RLWC: begin r = {x[14:0], c}; co = x[15]; wd = 1'b1; end
            msu_pkg::MSU_OPC_SRB: begin r = {9'h000, b[7:1]}; co = b[0]; left = 1'b0; end
            msu_pkg::MSU_OPC_RRBC: begin r = {8'h00, c, b[7:1]}; co = b[0]; left = 1'b0; end
            default: return;
        endcase
        neg = wd ? r[15] : r[7];
        zero = wd ? (r == 16'h0000) : (r[7:0] == 8'h00);
        rf[w[3:0]] = r[7:0];
        if (wd) rf[w[3:0] + 4'h1] = r[15:8];
        st[msu_pkg::MSU_B_NB] = neg;
        st[msu_pkg::MSU_B_ZB] = zero;
        if (left) st[msu_pkg::MSU_B_HC] = x[3];
        st[msu_pkg::MSU_B_CO] = co;
        if (w[msu_pkg::MSU_FLAG_BIT]) begin
            st[msu_pkg::MSU_B_N] = neg;
            st[msu_pkg::MSU_B_Z] = zero;
            if (left) st[msu_pkg::MSU_B_V] = wd ? x[15] ^ x[14] : b[7] ^ b[6];
            st[msu_pkg::MSU_B_C] = co;
        end
    endfunction

    task automatic run_op(input logic [15:0] w, input logic via_apb, input int unsigned gap);
        int base, n;
        bit ok;
        base = done_cnt;
        if (via_apb) wr(msu_pkg::MSU_A_ISSUE, {16'h0000, w});
        else begin
            i_msu_seq_model.send(w, gap, ok);
            chk({31'h0, ok}, 32'h1);
        end
        n = 0;
        while (done_cnt == base && n < 20) begin
            @(posedge pclk);
            n++;
        end
        chk(32'(done_cnt), 32'(base + 1));
        predict(w);
        n_ops++;
        last_w = w;
        chk({24'h0, sts}, {24'h0, st});
        rd(msu_pkg::MSU_A_STATUS, {24'h0, st});
        for (int i = 0; i < 16; i++) rd(ra(4'(i)), {24'h0, rf[i]});
    endtask

    initial begin
        #400000;
        n_errors++;
        summarize;
    end

    initial begin
        logic [31:0] r, q;
        logic e;
        logic [6:0] opc;
        logic [15:0] w;
        logic [7:0] b;
        int k;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        rd(msu_pkg::MSU_A_STATUS, 32'h0);
        rd(msu_pkg::MSU_A_COUNT, 32'h0);
        apb(1'b0, 12'h00c, 32'h0, q, e);
        chk({31'h0, e}, 32'h1);
        chk(q, 32'h0);
        apb(1'b1, 12'h042, 32'h5a, q, e);
        chk({31'h0, e}, 32'h1);
        for (int i = 0; i < 16; i++) rd(ra(4'(i)), 32'h0);
        for (int i = 0; i < 16; i++) begin
            r = rnd();
            rf[i] = r[7:0];
            wr(ra(4'(i)), {24'h0, r[7:0]});
        end
        for (int i = 0; i < 80; i++) begin
            r = rnd();
            k = (i < 20) ? i % 5 : int'(r[26:24]) % 6;
            case (k)
                0: opc = msu_pkg::MSU_OPC_RLBC;
                1: opc = msu_pkg::MSU_OPC_SLW;
                2: opc = msu_pkg::MSU_OPC_RLWC;
                3: opc = msu_pkg::MSU_OPC_SRB;
                4: opc = msu_pkg::MSU_OPC_RRBC;
                default: opc = r[31:25];
            endcase
            w = {opc, (i < 20) ? 1'((i / 5) % 2) : r[8], r[7:0]};
            st = {r[23:17], (i < 20) ? 1'(i / 10) : r[9]};
            b = r[31:24];
            if (i == 6) w[3:0] = 4'hf;
            if (i == 7) w[3:0] = w[7:4];
            if (i == 3) b = 8'h01;
            if (i == 11) begin
                b = 8'h00;
                w[4] = 1'b1;
            end
            wr(msu_pkg::MSU_A_STATUS, {24'h0, st});
            rf[w[7:4]] = b;
            wr(ra(w[7:4]), {24'h0, b});
            run_op(w, r[10], int'(r[14:13]));
        end
        rd(msu_pkg::MSU_A_COUNT, 32'(n_ops));
        rd(msu_pkg::MSU_A_ISSUE, {16'h0, last_w});
        summarize;
    end
endmodule
